// >>> design/phy_event_consts.svh
// Purpose: named offsets, field positions, reset values for the event/config bank
// Assumes: 32-bit APB, byte address = index * 4
// Notes: definitions only
`ifndef PHY_EVENT_CONSTS_SVH
`define PHY_EVENT_CONSTS_SVH
// ==========================================
// register indexes and byte addresses
`define IDX_MASK 5'h12
`define IDX_STATUS 5'h13
`define IDX_CONFIG 5'h14
`define ADDR_MASK 12'h048
`define ADDR_STATUS 12'h04C
`define ADDR_CONFIG 12'h050
// ==========================================
// reset values
`define RST_MASK 16'h0000
`define RST_STATUS 16'h0000
`define RST_CONFIG 16'h2947
// ==========================================
// status register: clear-on-read bits, read-only sticky bits
`define COR_BITS 16'hFDF1
`define RO_BITS 16'h020E
// config register: writable bits (14, 12, 7 reserved)
`define CFG_WRITE_BITS 16'hAF7F
// config field positions
`define CFG_PROBE 15
`define CFG_IRQ_POL 13
`define CFG_RETRY_HI 11
`define CFG_RETRY_LO 10
`define CFG_DS_EN 9
`define CFG_DS_ENERGY 8
`define CFG_DS_LOWEST 6
`define CFG_TXCLK_HI 5
`define CFG_TXCLK_LO 4
`define CFG_COL_FD 3
`define CFG_OLD_SCR 2
`define CFG_SEMI_MASTER 1
`define CFG_SEMI_SLAVE 0
// transmit clock select codes
`define TXCLK_SLOW 2'h0
`define TXCLK_FAST 2'h1
`endif

// >>> design/phy_event_pkg.sv
// Purpose: types for the event/config bank
// Assumes: nothing
// Notes: constants live in phy_event_consts.svh
`default_nettype none
package phy_event_pkg;
    // ==========================================
    // apb request from master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;
    // decoded configuration outputs
    typedef struct packed {
        logic powered_device_probe_en;
        logic [3:0] downshift_retry_count;
        logic downshift_en;
        logic downshift_energy_mode_en;
        logic downshift_lowest_rate_en;
        logic tx_clock_slow;
        logic tx_clock_fast;
        logic collision_in_full_duplex_en;
        logic old_scrambler_auto_en;
        logic semi_cross_master_en;
        logic semi_cross_slave_en;
    } config_out_type;
endpackage
`default_nettype wire

// >>> design/phy_event_bank.sv
// Purpose: event status (clear on read) and general configuration registers on APB
// Assumes: event inputs come from other clock domains and are one-bit pulses or levels
// Notes: each rule below is tagged again at the logic that carries it out
// Operation
// R01: each status bit sets when its event happened since the last status read
// R02: status bits record events whether or not the mask enables them
// R03: clear-on-read bits latch high, hold, and clear on a status read
// R04: negotiation fault bit 15, page received bit 12, negotiation done bit 11
// R05: rate change bit 14, duplex change bit 13, link state change bit 10
// R06: pair swap change bit 6, downshift event bit 5, sleep change bit 4
// R07: converter fifo overflow or underflow latches bit 7
// R08: jabber latches bit 0, spurious carrier latches bit 8
// R09: polarity change reported in bit 1, read-only, not cleared by read
// R10: energy efficient fault sets read-only bit 9
// R11: wake or pattern packet sets read-only bit 3
// R12: mac buffer fault sets read-only bit 2; indication is unproven
// R13: config bit 15 enables powered device probe; hardware may update it
// R14: config bit 13 selects interrupt polarity, 0 active high, 1 active low
// R15: bits 11-10 pick 1, 2, 4 or 8 gigabit attempts, reset code 2
// R16: config bit 9 enables downshift, reset disabled
// R17: bit 8 downshift when no energy on pairs c and d, reset set
// R18: bit 6 allows fallback to 10 mb/s, reset set
// R19: bits 5-4 pick transmit clock 2.5 or 25 mhz, codes 2 and 3 off
// R20: bit 3 enables collision indication in full duplex
// R21: bit 2 lets gigabit master pick old scrambler mode, reset set
// R22: bits 1 and 0 enable semi-cross in master and slave, reset set
// R23: interrupt output asserts for a set status bit whose mask bit is set
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "phy_event_consts.svh"
`default_nettype none

module phy_event_bank (
    input wire logic clock_in, // 25 mhz core clock
    input wire logic nrst_in, // synchronous reset, active low
    input wire phy_event_pkg::apb_req_type apb_in, // apb request
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error on unmapped address
    input wire logic [15:0] event_in, // asynchronous event sources, one per bit
    input wire logic probe_clear_in, // hardware turns the probe enable off
    output logic irq_out, // interrupt pin level, polarity applied
    output phy_event_pkg::config_out_type config_out // decoded configuration
);
    import phy_event_pkg::*;

    // ==========================================
    // synchronisers and edge detect
    logic [15:0] ev_meta;
    logic [15:0] ev_sync;
    logic [15:0] ev_prev;
    logic probe_meta;
    logic probe_sync;
    logic [15:0] event_status;
    logic [15:0] interrupt_mask;
    logic [15:0] general_config_two;
    logic access_done;

    // two flip-flops on every event input and on the probe clear input
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            ev_meta <= 16'h0000;
            ev_sync <= 16'h0000;
            ev_prev <= 16'h0000;
            probe_meta <= 1'b0;
            probe_sync <= 1'b0;
        end else begin
            ev_meta <= event_in;
            ev_sync <= ev_meta;
            ev_prev <= ev_sync;
            probe_meta <= probe_clear_in;
            probe_sync <= probe_meta;
        end
    end

    // rising edge of each synchronised source is one event
    wire [15:0] ev_pulse = ev_sync & ~ev_prev;

    // ==========================================
    // apb decode
    wire setup_phase = apb_in.psel & ~apb_in.penable;
    wire access_phase = apb_in.psel & apb_in.penable & ~access_done;
    wire hit_mask = apb_in.paddr == `ADDR_MASK;
    wire hit_status = apb_in.paddr == `ADDR_STATUS;
    wire hit_config = apb_in.paddr == `ADDR_CONFIG;
    wire hit_any = hit_mask | hit_status | hit_config;
    wire do_write = access_phase & apb_in.pwrite;
    wire do_read = access_phase & ~apb_in.pwrite;
    // R03: read clears
    wire status_read = do_read & hit_status;

    // read mux
    wire [15:0] read_word = hit_mask ? interrupt_mask :
        hit_status ? event_status :
        hit_config ? general_config_two : 16'h0000;

    // ==========================================
    // event status: set wins over the read clear
    // R01: latch since read
    // R02: mask not involved
    // R04: negotiation bits 15 12 11
    // R05: change bits 14 13 10
    // R06: bits 6 5 4
    // R07: fifo bit 7
    // R08: jabber, carrier
    // R09: polarity not cleared
    // R10: bit 9
    // R11: bit 3
    // R12: bit 2
    wire [15:0] read_clear = status_read ? `COR_BITS : 16'h0000;
    wire [15:0] next_event_status = (event_status & ~read_clear) | ev_pulse;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            event_status <= `RST_STATUS;
        end else begin
            event_status <= next_event_status;
        end
    end

    // ==========================================
    // mask and configuration registers
    // R13: hardware clear of probe
    wire [15:0] cfg_written = (apb_in.pwdata[15:0] & `CFG_WRITE_BITS);
    wire [15:0] cfg_after_write = (do_write & hit_config) ? cfg_written : general_config_two;
    wire [15:0] probe_drop = probe_sync ? (16'h0001 << `CFG_PROBE) : 16'h0000;
    wire [15:0] next_general_config_two = cfg_after_write & ~probe_drop;
    wire [15:0] next_interrupt_mask = (do_write & hit_mask) ? apb_in.pwdata[15:0] : interrupt_mask;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            general_config_two <= `RST_CONFIG;
            interrupt_mask <= `RST_MASK;
        end else begin
            general_config_two <= next_general_config_two;
            interrupt_mask <= next_interrupt_mask;
        end
    end

    // ==========================================
    // apb answer: one wait state, ready registered
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            access_done <= 1'b0;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else begin
            access_done <= access_phase;
            pready_out <= access_phase;
            pslverr_out <= access_phase & ~hit_any;
            if (do_read) begin
                prdata_out <= {16'h0000, read_word};
            end else if (setup_phase) begin
                prdata_out <= 32'h00000000;
            end
        end
    end

    // ==========================================
    // interrupt pin and configuration outputs
    // R23: masked status raises irq
    wire irq_active = |(next_event_status & interrupt_mask);
    // R15: attempt count decode
    wire [1:0] retry_code = general_config_two[`CFG_RETRY_HI:`CFG_RETRY_LO];
    // R19: tx clock select
    wire [1:0] clk_code = general_config_two[`CFG_TXCLK_HI:`CFG_TXCLK_LO];

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
            config_out <= '0;
        end else begin
            // R14: polarity select
            irq_out <= irq_active ^ general_config_two[`CFG_IRQ_POL];
            // R13: probe enable
            config_out.powered_device_probe_en <= general_config_two[`CFG_PROBE];
            config_out.downshift_retry_count <= 4'h1 << retry_code;
            // R16: downshift enable
            config_out.downshift_en <= general_config_two[`CFG_DS_EN];
            // R17: energy mode
            config_out.downshift_energy_mode_en <= general_config_two[`CFG_DS_ENERGY];
            // R18: lowest rate
            config_out.downshift_lowest_rate_en <= general_config_two[`CFG_DS_LOWEST];
            config_out.tx_clock_slow <= clk_code == `TXCLK_SLOW;
            config_out.tx_clock_fast <= clk_code == `TXCLK_FAST;
            // R20: collision full duplex
            config_out.collision_in_full_duplex_en <= general_config_two[`CFG_COL_FD];
            // R21: old scrambler auto
            config_out.old_scrambler_auto_en <= general_config_two[`CFG_OLD_SCR];
            // R22: semi-cross enables
            config_out.semi_cross_master_en <= general_config_two[`CFG_SEMI_MASTER];
            config_out.semi_cross_slave_en <= general_config_two[`CFG_SEMI_SLAVE];
        end
    end
endmodule

`default_nettype wire

// >>> tb/phy_event_props.sv
// Purpose: port checks for phy_event_bank
// Assumes: one clock, reset sync active low
// Notes: bound to every bank instance
`timescale 1ns/10ps
`include "phy_event_consts.svh"
`default_nettype none
module phy_event_props (
    input wire logic clock_in, // clock
    input wire logic nrst_in, // reset
    input wire phy_event_pkg::apb_req_type apb_in, // apb request
    input wire logic [31:0] prdata_out, // read data
    input wire logic pready_out, // ready
    input wire logic pslverr_out, // error
    input wire logic [15:0] event_in, // events
    input wire logic probe_clear_in, // probe clear
    input wire logic irq_out, // interrupt
    input wire phy_event_pkg::config_out_type config_out // decode
);
    import phy_event_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // ==========================================
    // bus timing and field decode
    AST_READY_PULSE: assert property (pready_out |=> !pready_out) else $error("ready held");
    AST_ONE_WAIT: assert property (
        apb_in.psel && apb_in.penable && !pready_out |=> pready_out) else $error("no ready");
    AST_ERR_READY: assert property (pslverr_out |-> pready_out) else $error("lone err");
    AST_HIGH_ZERO: assert property (
        pready_out |-> prdata_out[31:16] == 16'h0000) else $error("upper data");
    AST_CFG_RSVD: assert property (
        pready_out && !apb_in.pwrite && apb_in.paddr == `ADDR_CONFIG
        |-> (prdata_out & 32'h0000_5080) == 32'h0) else $error("reserved bits");
    AST_RETRY_ONEHOT: assert property (
        $past(nrst_in) |-> $onehot(config_out.downshift_retry_count)) else $error("retry count");
    AST_TXCLK_EXCL: assert property (
        !(config_out.tx_clock_slow && config_out.tx_clock_fast)) else $error("tx clock");
    AST_PROBE_CLEAR: assert property (
        probe_clear_in [*6] |-> !config_out.powered_device_probe_en) else $error("probe set");
endmodule
bind phy_event_bank phy_event_props props_u (.clock_in, .nrst_in, .apb_in, .prdata_out,
    .pready_out, .pslverr_out, .event_in, .probe_clear_in, .irq_out, .config_out);
`default_nettype wire

// >>> tb/phy_event_bank_test.sv
// Purpose: self-checking bench for phy_event_bank
// Assumes: apb answers with one wait state
// Notes: events held 3 cycles high and low
`timescale 1ns/10ps
`include "phy_event_consts.svh"
`default_nettype none
module phy_event_bank_test;
    import phy_event_pkg::*;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    apb_req_type apb_in = '0;
    logic [15:0] event_in = 16'h0000;
    logic probe_clear_in = 1'b0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic irq_out;
    config_out_type config_out;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] q;
    logic e;
    phy_event_bank dut_u (.clock_in, .nrst_in, .apb_in, .prdata_out, .pready_out,
        .pslverr_out, .event_in, .probe_clear_in, .irq_out, .config_out);
    // ==========================================
    // clock, timeout, helpers
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", w, x, g);
        end
    endtask
    // setup, access, hold until ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_in);
        apb_in <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock_in);
        apb_in.penable <= 1'b1;
        // wait for ready however long; only the bench timeout ends a hang
        do begin
            @(posedge clock_in);
        end while (pready_out !== 1'b1);
        q = prdata_out;
        e = pslverr_out;
        apb_in <= '0;
    endtask
    task automatic ev(input logic [15:0] v);
        event_in <= v;
        repeat (3) @(posedge clock_in);
        event_in <= 16'h0000;
        repeat (3) @(posedge clock_in);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        chk("irq idle", 32'h1, {31'h0, irq_out});
        apb(1'b0, `ADDR_STATUS, 32'h0);
        chk("status rst", 32'h0, q);
        chk("status err", 32'h0, {31'h0, e});
        apb(1'b0, `ADDR_CONFIG, 32'h0);
        chk("config rst", 32'h2947, q);
        chk("decode rst", {18'h0, 1'b0, 4'h4, 3'h3, 2'h2, 4'h7}, {18'h0, config_out});
        $display("reset test done");
    endtask
    task automatic t_events();
        ev(16'hFFFF);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        chk("status all", 32'hFFFF, q);
        chk("irq masked", 32'h1, {31'h0, irq_out});
        apb(1'b0, `ADDR_STATUS, 32'h0);
        chk("status kept", 32'h020E, q);
        $display("event test done");
    endtask
    task automatic t_irq();
        apb(1'b1, `ADDR_MASK, 32'h1);
        ev(16'h0001);
        chk("irq low", 32'h0, {31'h0, irq_out});
        apb(1'b1, `ADDR_CONFIG, 32'h0947);
        repeat (2) @(posedge clock_in);
        chk("irq high", 32'h1, {31'h0, irq_out});
        apb(1'b0, `ADDR_STATUS, 32'h0);
        repeat (2) @(posedge clock_in);
        chk("irq clear", 32'h0, {31'h0, irq_out});
        $display("irq test done");
    endtask
    task automatic t_config();
        logic [15:0] f;
        for (int c = 0; c < 4; c++) begin
            f = 16'(c);
            apb(1'b1, `ADDR_CONFIG, {16'hFFFF, 16'hF3CF | f << 10 | f << 4});
            apb(1'b0, `ADDR_CONFIG, 32'h0);
            chk("config rw", {16'h0, 16'hA34F | f << 10 | f << 4}, q);
            chk("decode", {18'h0, 1'b1, 4'h1 << c, 3'h7, c == 0, c == 1, 4'hF},
                {18'h0, config_out});
        end
        probe_clear_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        probe_clear_in <= 1'b0;
        apb(1'b0, `ADDR_CONFIG, 32'h0);
        chk("probe clear", 32'h2F7F, q);
        $display("config test done");
    endtask
    task automatic t_refuse();
        apb(1'b0, 12'h060, 32'h0);
        chk("unmapped", 32'h1, {q[30:0], e});
        apb(1'b1, `ADDR_STATUS, 32'hFFFF);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        chk("status wr", 32'h020E, q);
        // event lands on the clearing edge of a status read: the set must survive
        event_in <= 16'h0010;
        apb(1'b0, `ADDR_STATUS, 32'h0);
        event_in <= 16'h0000;
        chk("read race", 32'h020E, q);
        apb(1'b0, `ADDR_STATUS, 32'h0);
        chk("set wins", 32'h021E, q);
        $display("refuse test done");
    endtask
    task final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        t_reset();
        t_events();
        t_irq();
        t_config();
        t_refuse();
        final_report();
    end
endmodule
`default_nettype wire
